//--- hdl/usb_clk_div.sv
// Enable-pulse divider for the USB controller clock.
// Assumes ratio comes from a register on the same clock.
`timescale 1ns/100ps
`include "usb_status_defines.svh"
module usb_clk_div
  import usb_status_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire clk_ratio_t ratio,
  output logic            tick
);
  div_state_t st_q;
  div_state_t st_d;

  // Code n divides by n+1; a new code is compared with the count from the first cycle it is present
  always_comb begin
    st_d = st_q;
    if (st_q.cnt >= ratio) begin
      st_d.cnt  = `RATIO_RESET_VAL;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt  = st_q.cnt + `DIV_STEP;
      st_d.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

  // Undivided code gives an enable on every cycle
  chk_div_full_rate: assert property (@(posedge clk) disable iff (rst) // R12
    (ratio == `RATIO_RESET_VAL && $past(ratio) == `RATIO_RESET_VAL
     && !$past(rst)) |=> tick)
    else $error("divider code 0 did not tick every cycle");
endmodule

//--- hdl/usb_frame_count_status.sv
// USB frame number, received byte count and clock divider status SFRs.
// Assumes USB logic inputs and the core SFR access run on the same clock as the core.
//
// Overview of operation
// [R1] Byte count reads show the endpoint picked by the select input.
// [R2] A seven-bit count holds the payload bytes of the last data packet.
// [R3] Reserved bits read as zero and writes to them are dropped.
// [R4] The low frame register holds frame number bits seven to zero.
// [R5] The high frame register low three bits hold frame bits ten to eight.
// [R6] The frame number is loaded from the latest Start-of-Frame packet.
// [R7] A Start-of-Frame with a bad CRC leaves the stored frame unchanged.
// [R8] Bit five of the high frame register flags a good frame CRC.
// [R9] Bit four of the high frame register flags a bad frame CRC.
// [R10] Both CRC flags are refreshed by every Start-of-Frame packet.
// [R11] The Start-of-Frame event fires right after its PID arrives.
// [R12] A two-bit field sets the USB controller clock divide ratio.
// [R13] Counts update at packet end; code n divides the clock by n+1.
`timescale 1ns/100ps
`include "usb_status_defines.svh"
module usb_frame_count_status
  import usb_status_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire sfr_req_t  sfr_req,
  output sfr_byte_t      sfr_rdata,
  input  wire ep_sel_t   endpoint_select,
  input  wire rx_pkt_t   rx_pkt,
  input  wire sof_info_t sof_info,
  output logic           sof_irq,
  output clk_ratio_t     usb_clk_ratio,
  output logic           usb_clk_tick
);
  status_state_t st_q;
  status_state_t st_d;
  sfr_byte_t     frame_high;
  sfr_byte_t     count_view;

  // Register images with reserved bits forced low
  always_comb begin
    frame_high = `REG_RESET_VAL; // R3
    frame_high[`FRAME_HIGH_W-1:0] =
      st_q.sof_frame_index[`FRAME_W-1:`FRAME_LOW_W]; // R5
    frame_high[`FRAME_OK_BIT]  = st_q.frame_check_good; // R8
    frame_high[`FRAME_BAD_BIT] = st_q.frame_check_bad; // R9
    count_view = `REG_RESET_VAL; // R3
    count_view[`BYTE_CNT_W-1:0] =
      st_q.rx_byte_total[endpoint_select]; // R1
  end

  // Next state: packet reports, frame capture, SFR access
  always_comb begin
    st_d = st_q;
    st_d.sof_irq = sof_info.pid_seen; // R11
    // Only a finished packet touches the count, so a read mid-packet
    // still shows the previous packet's size
    if (rx_pkt.done) begin
      st_d.rx_byte_total[rx_pkt.ep] = rx_pkt.len; // R2 R13
    end
    if (sof_info.done) begin
      st_d.frame_check_good = sof_info.crc_ok; // R8 R10
      st_d.frame_check_bad  = !sof_info.crc_ok; // R9 R10
      if (sof_info.crc_ok) begin
        st_d.sof_frame_index = sof_info.frame; // R6 R7
      end
    end
    // Only the ratio bits are stored; the upper six are discarded
    if (sfr_req.wr && sfr_req.addr == `CLK_DIV_ADDR) begin
      st_d.usb_clk_ratio = sfr_req.wdata[`RATIO_W-1:0]; // R3 R12
    end
    // Read data is captured on the strobe, unmapped reads give zero
    if (sfr_req.rd) begin
      if (sfr_req.addr == `FRAME_LOW_ADDR) begin
        st_d.rdata = st_q.sof_frame_index[`FRAME_LOW_W-1:0]; // R4
      end else if (sfr_req.addr == `FRAME_HIGH_ADDR) begin
        st_d.rdata = frame_high;
      end else if (sfr_req.addr == `BYTE_COUNT_ADDR) begin
        st_d.rdata = count_view; // R1
      end else if (sfr_req.addr == `CLK_DIV_ADDR) begin
        st_d.rdata = `REG_RESET_VAL;
        st_d.rdata[`RATIO_W-1:0] = st_q.usb_clk_ratio; // R3
      end else begin
        st_d.rdata = `REG_RESET_VAL;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Divider on the core clock; controller logic uses the tick as enable
  usb_clk_div u_clk_div (
    .clk   (clk),
    .rst   (rst),
    .ratio (st_q.usb_clk_ratio),
    .tick  (usb_clk_tick)
  );

  assign sfr_rdata     = st_q.rdata;
  assign sof_irq       = st_q.sof_irq;
  assign usb_clk_ratio = st_q.usb_clk_ratio;

  // Checking sequences
  sequence sof_good_s;
    sof_info.done && sof_info.crc_ok;
  endsequence

  sequence sof_bad_s;
    sof_info.done && !sof_info.crc_ok;
  endsequence

  sequence rd_count_s;
    sfr_req.rd && sfr_req.addr == `BYTE_COUNT_ADDR;
  endsequence

  sequence rd_high_s;
    sfr_req.rd && sfr_req.addr == `FRAME_HIGH_ADDR;
  endsequence

  sequence rd_unmapped_s;
    sfr_req.rd && sfr_req.addr != `FRAME_LOW_ADDR
      && sfr_req.addr != `FRAME_HIGH_ADDR
      && sfr_req.addr != `BYTE_COUNT_ADDR
      && sfr_req.addr != `CLK_DIV_ADDR;
  endsequence

  // Packet end loads the count of its own endpoint
  chk_count_load: assert property (@(posedge clk) disable iff (rst) // R2
    rx_pkt.done |=> st_q.rx_byte_total[$past(rx_pkt.ep)] == $past(rx_pkt.len))
    else $error("byte count not loaded at packet end");

  // Count read follows the select input, top bit zero
  chk_count_select: assert property (@(posedge clk) disable iff (rst) // R1
    rd_count_s |=> sfr_rdata[`BYTE_CNT_W-1:0] ==
      $past(st_q.rx_byte_total[endpoint_select]) && !sfr_rdata[`SFR_W-1])
    else $error("byte count read shows wrong endpoint");

  // Good frame loads the number and sets only the good flag
  chk_frame_good: assert property (@(posedge clk) disable iff (rst) // R6
    sof_good_s |=> st_q.sof_frame_index == $past(sof_info.frame)
      && st_q.frame_check_good && !st_q.frame_check_bad)
    else $error("good frame not captured");

  // Bad frame keeps the number and sets only the bad flag
  chk_frame_hold: assert property (@(posedge clk) disable iff (rst) // R7
    sof_bad_s |=> $stable(st_q.sof_frame_index)
      && st_q.frame_check_bad && !st_q.frame_check_good)
    else $error("corrupted frame changed the stored number");

  // Flags hold between frames
  chk_flags_stable: assert property (@(posedge clk) disable iff (rst) // R10
    !sof_info.done |=> $stable(st_q.frame_check_good)
      && $stable(st_q.frame_check_bad))
    else $error("crc flags moved without a frame");

  // High frame byte: top frame bits, two flags, zeros elsewhere
  chk_high_layout: assert property (@(posedge clk) disable iff (rst) // R5
    rd_high_s |=> sfr_rdata[`FRAME_HIGH_W-1:0] ==
      $past(st_q.sof_frame_index[`FRAME_W-1:`FRAME_LOW_W])
      && sfr_rdata[`FRAME_OK_BIT] == $past(st_q.frame_check_good)
      && sfr_rdata[`FRAME_BAD_BIT] == $past(st_q.frame_check_bad)
      && sfr_rdata[`SFR_W-1:`FRAME_OK_BIT+1] == '0
      && !sfr_rdata[`FRAME_HIGH_W])
    else $error("high frame register layout wrong");

  // Low frame byte is frame bits seven to zero
  chk_low_read: assert property (@(posedge clk) disable iff (rst) // R4
    (sfr_req.rd && sfr_req.addr == `FRAME_LOW_ADDR) |=>
      sfr_rdata == $past(st_q.sof_frame_index[`FRAME_LOW_W-1:0]))
    else $error("low frame register read wrong");

  // Event lands one cycle after the PID
  chk_sof_event: assert property (@(posedge clk) disable iff (rst) // R11
    sof_info.pid_seen |=> sof_irq ##1 (sof_irq == $past(sof_info.pid_seen)))
    else $error("sof event not one cycle after pid");

  // Write to the divider address stores the code
  chk_ratio_write: assert property (@(posedge clk) disable iff (rst) // R12
    (sfr_req.wr && sfr_req.addr == `CLK_DIV_ADDR) |=>
      usb_clk_ratio == $past(sfr_req.wdata[`RATIO_W-1:0]))
    else $error("divider code not written");

  // Divider read shows the code with zeros above it
  chk_ratio_read: assert property (@(posedge clk) disable iff (rst) // R3
    (sfr_req.rd && sfr_req.addr == `CLK_DIV_ADDR) |=>
      sfr_rdata == {6'h00, $past(usb_clk_ratio)})
    else $error("divider register reserved bits not zero");

  // Event follows the PID: no PID, no event on the next cycle
  chk_irq_quiet: assert property (@(posedge clk) disable iff (rst) // R11
    !sof_info.pid_seen |=> !sof_irq)
    else $error("sof event without a pid");

  // Counts move only at packet end, never mid-packet
  chk_count_keep: assert property (@(posedge clk) disable iff (rst) // R13
    !rx_pkt.done |=> $stable(st_q.rx_byte_total))
    else $error("byte count moved without a packet");

  // A report for one endpoint leaves the opposite endpoint alone
  chk_count_other: assert property (@(posedge clk) disable iff (rst) // R1
    rx_pkt.done |=> st_q.rx_byte_total[~$past(rx_pkt.ep)] ==
      $past(st_q.rx_byte_total[~rx_pkt.ep]))
    else $error("packet report touched another endpoint");

  // Stored frame changes only when a frame is evaluated
  chk_frame_quiet: assert property (@(posedge clk) disable iff (rst) // R6
    !sof_info.done |=> $stable(st_q.sof_frame_index))
    else $error("frame number moved without a frame");

  // Divider code holds between writes to its own address
  chk_ratio_keep: assert property (@(posedge clk) disable iff (rst) // R12
    !(sfr_req.wr && sfr_req.addr == `CLK_DIV_ADDR) |=>
      $stable(usb_clk_ratio))
    else $error("divider code moved without a write");

  // Unmapped addresses read back as all zeros
  chk_unmapped_zero: assert property (@(posedge clk) disable iff (rst) // R3
    rd_unmapped_s |=> sfr_rdata == `REG_RESET_VAL)
    else $error("unmapped read not zero");
endmodule

//--- pkg/usb_status_defines.svh
// Constants for the USB frame, byte count and clock divider status block.
// Assumes inclusion by the package and by design files that decode SFRs.
`ifndef USB_STATUS_DEFINES_SVH
`define USB_STATUS_DEFINES_SVH

// SFR addresses
`define FRAME_LOW_ADDR    8'hBA
`define FRAME_HIGH_ADDR   8'hBB
`define BYTE_COUNT_ADDR   8'hE2
`define CLK_DIV_ADDR      8'hEA

// Widths and sizes
`define EP_COUNT          4
`define EP_SEL_W          2
`define BYTE_CNT_W        7
`define FRAME_W           11
`define FRAME_LOW_W       8
`define FRAME_HIGH_W      3
`define RATIO_W           2
`define SFR_W             8

// Field positions inside the high frame register
`define FRAME_OK_BIT      5
`define FRAME_BAD_BIT     4

// Reset values and the divider count step
`define REG_RESET_VAL     8'h00
`define FRAME_RESET_VAL   11'h000
`define COUNT_RESET_VAL   7'h00
`define RATIO_RESET_VAL   2'h0
`define DIV_STEP          2'h1

`endif

//--- pkg/usb_status_pkg.sv
// Types shared by the USB status block and its clock divider.
// Assumes the defines header is on the include path.
package usb_status_pkg;
  `include "usb_status_defines.svh"

  typedef logic [`BYTE_CNT_W-1:0] byte_total_t;
  typedef logic [`FRAME_W-1:0]    frame_index_t;
  typedef logic [`RATIO_W-1:0]    clk_ratio_t;
  typedef logic [`SFR_W-1:0]      sfr_byte_t;
  typedef logic [`EP_SEL_W-1:0]   ep_sel_t;

  // Core side special-function register access
  typedef struct packed {
    sfr_byte_t addr;
    logic      rd;
    logic      wr;
    sfr_byte_t wdata;
  } sfr_req_t;

  // Completed data packet report from the receive engine
  typedef struct packed {
    logic        done;
    ep_sel_t     ep;
    byte_total_t len;
  } rx_pkt_t;

  // Start-of-Frame progress from the packet decoder
  typedef struct packed {
    logic         pid_seen;
    logic         done;
    frame_index_t frame;
    logic         crc_ok;
  } sof_info_t;

  // Whole state of the status block
  typedef struct packed {
    logic [`EP_COUNT-1:0][`BYTE_CNT_W-1:0] rx_byte_total;
    frame_index_t sof_frame_index;
    logic         frame_check_good;
    logic         frame_check_bad;
    clk_ratio_t   usb_clk_ratio;
    sfr_byte_t    rdata;
    logic         sof_irq;
  } status_state_t;

  // Whole state of the clock divider
  typedef struct packed {
    clk_ratio_t cnt;
    logic       tick;
  } div_state_t;
endpackage

//--- verification/usb_frame_count_status_tb_top.sv
// Self-checking bench for the USB frame, byte count and divider SFRs.
// Assumes the host model drives the packet and SOF reports.
`timescale 1ns/100ps
module usb_frame_count_status_tb_top
  import usb_status_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  sfr_req_t     sfr_req = '0;
  ep_sel_t      endpoint_select = '0;
  sfr_byte_t    sfr_rdata;
  logic         sof_irq;
  logic         usb_clk_tick;
  clk_ratio_t   usb_clk_ratio;
  rx_pkt_t      rx_pkt;
  sof_info_t    sof_info;
  int           n_mismatch = 0;
  int           samples_checked = 0;
  logic [31:0]  rs = 32'h19;
  byte_total_t  cnt_exp [4] = '{7'h00, 7'h00, 7'h00, 7'h00};
  sfr_byte_t    adr [5] = '{8'hBA, 8'hBB, 8'hE2, 8'hEA, 8'h00};
  frame_index_t fr_exp = '0;

  usb_frame_count_status i_dut (
    .clk             (clk),
    .rst             (rst),
    .sfr_req         (sfr_req),
    .sfr_rdata       (sfr_rdata),
    .endpoint_select (endpoint_select),
    .rx_pkt          (rx_pkt),
    .sof_info        (sof_info),
    .sof_irq         (sof_irq),
    .usb_clk_ratio   (usb_clk_ratio),
    .usb_clk_tick    (usb_clk_tick)
  );

  usb_host_model host (
    .clk      (clk),
    .rx_pkt   (rx_pkt),
    .sof_info (sof_info)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  // Repeatable stimulus source
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  // Expected high frame byte: flags exclusive, frame bits ten to eight
  function automatic sfr_byte_t hi_exp(frame_index_t f, logic ok);
    return {2'b00, ok, ~ok, 1'b0, f[10:8]};
  endfunction

  task automatic chk(input sfr_byte_t s, input sfr_byte_t e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask

  // Read strobe one cycle; data lands on the same edge that takes it
  task automatic rdc(input sfr_byte_t a, input sfr_byte_t e);
    @(posedge clk) sfr_req <= '{a, 1'b1, 1'b0, 8'h00};
    @(posedge clk) sfr_req.rd <= 1'b0;
    #1 chk(sfr_rdata, e);
  endtask

  task automatic wr(input sfr_byte_t a, input sfr_byte_t d);
    @(posedge clk) sfr_req <= '{a, 1'b0, 1'b1, d};
    @(posedge clk) sfr_req.wr <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard
  initial begin
    #1000000;
    n_mismatch++;
    give_verdict();
  end

  // Main sequence
  initial begin
    logic [31:0]  r;
    frame_index_t f;
    logic         ok;
    byte_total_t  n;
    int           k;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values; a write to a read-only place must not stick
    wr(8'hBA, 8'h5A);
    foreach (adr[i]) rdc(adr[i], 8'h00);
    // Every divider code: field, register and tick rate
    for (int c = 0; c < 4; c++) begin
      wr(8'hEA, {6'h00, c[1:0]});
      #1 chk({6'h00, usb_clk_ratio}, c[7:0]);
      rdc(8'hEA, c[7:0]);
      repeat (8) @(posedge clk);
      k = 0;
      for (int j = 0; j < 12; j++) begin
        @(posedge clk);
        #1 k += usb_clk_tick;
      end
      chk(k[7:0], 8'(12 / (c + 1)));
    end
    // SOFs: first one corrupted, then all-ones frame, then random
    for (int i = 0; i < 20; i++) begin
      r = xs();
      f = (i == 1) ? 11'h7FF : r[10:0];
      ok = (i == 1) | ((i > 1) & r[11]);
      host.sof_pid();
      #1 chk({7'h00, sof_irq}, 8'h01);
      host.sof_end(f, ok);
      if (ok) fr_exp = f;
      rdc(8'hBA, fr_exp[7:0]);
      rdc(8'hBB, hi_exp(fr_exp, ok));
    end
    // Packets on random endpoints, read through a random selection
    for (int i = 0; i < 16; i++) begin
      r = xs();
      n = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : r[6:0];
      host.pkt(r[9:8], n);
      cnt_exp[r[9:8]] = n;
      endpoint_select <= r[13:12];
      rdc(8'hE2, {1'b0, cnt_exp[r[13:12]]});
    end
    give_verdict();
  end
endmodule

//--- verification/usb_host_model.sv
// Host side stand-in: sends SOF progress and data packet reports.
// Assumes the bench calls its tasks from the clk domain.
`timescale 1ns/100ps
module usb_host_model
  import usb_status_pkg::*;
(
  input  wire logic clk,
  output rx_pkt_t   rx_pkt,
  output sof_info_t sof_info
);
  // Idle at time zero
  initial begin
    rx_pkt   = '0;
    sof_info = '0;
  end

  // SOF PID pulse; the frame follows in a separate call
  task automatic sof_pid();
    @(posedge clk) sof_info.pid_seen <= 1'b1;
    @(posedge clk) sof_info.pid_seen <= 1'b0;
  endtask

  // Frame and CRC verdict; stale fields inverted so they never look valid
  task automatic sof_end(input frame_index_t f, input logic ok);
    @(posedge clk) sof_info <= '{1'b0, 1'b1, f, ok};
    @(posedge clk) sof_info <= '{1'b0, 1'b0, ~f, ~ok};
  endtask

  // One finished data packet
  task automatic pkt(input ep_sel_t e, input byte_total_t n);
    @(posedge clk) rx_pkt <= '{1'b1, e, n};
    @(posedge clk) rx_pkt <= '{1'b0, ~e, ~n};
  endtask
endmodule
